// ===== dv/sac_converter_control_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module sac_converter_control_tb;
    localparam logic [7:0] CTL = sac_pkg::OFF_STATUS_CONTROL;
    localparam logic [7:0] RES = sac_pkg::OFF_RESULT;
    localparam logic [7:0] PRE = sac_pkg::OFF_CLOCK_PRESCALE;
    logic i_clk, i_sys_rst, i_wr, i_rd, i_stop_mode, i_wait_mode;
    logic [7:0] i_addr, i_wdata, o_rdata, i_core_result, bias, rv;
    logic o_core_power, o_conv_irq, o_result_settled;
    logic [1:0] o_core_ref_sel;
    logic [5:0] o_pin_analog;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    sac_converter_control i_sac_converter_control (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_stop_mode(i_stop_mode), .i_wait_mode(i_wait_mode),
        .i_core_result(i_core_result), .o_core_power(o_core_power),
        .o_core_ref_sel(o_core_ref_sel), .o_pin_analog(o_pin_analog),
        .o_conv_irq(o_conv_irq), .o_result_settled(o_result_settled));
    sac_core_model i_sac_core_model (.i_clk(i_clk), .i_power(o_core_power),
        .i_ref_sel(o_core_ref_sel), .i_pin_analog(o_pin_analog),
        .i_bias(bias), .o_result(i_core_result));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Hang guard, far above the few thousand cycles needed
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    // Poll the done flag, n counts elapsed cycles
    task automatic poll(input int lim, output int n);
        n = 0;
        rv = 8'h00;
        while (rv[7] !== 1'b1 && n < lim) begin
            rd(CTL);
            n += 2;
        end
    endtask
    task automatic t_reset();
        rd(CTL);
        chk(rv, 8'h1f);
        rd(PRE);
        chk(rv, 8'h00);
        wr(RES, 8'h77);
        wr(8'h40, 8'h23);
        rd(8'h40);
        chk(rv, 8'h00);
        rd(CTL);
        chk(rv, 8'h1f);
        chk({7'h00, o_core_power}, 8'h00);
    endtask
    task automatic t_single(input logic [4:0] ch, input logic [2:0] dv);
        int n;
        int nd;
        logic [7:0] ev;
        nd = dv[2] ? 16 : (1 << dv);
        ev = ch == 5'h1d ? 8'hff : ch == 5'h1e ? 8'h00 : {ch[3:0], 4'h3};
        wr(PRE, {dv, 5'h00});
        rd(PRE);
        chk(rv, {dv, 5'h00});
        wr(CTL, {3'h0, ch});
        #1 if (ch < 5'h06) chk({2'h0, o_pin_analog}, 8'h01 << ch);
        poll(30 * nd, n);
        // Write edge, arming tick, twelve counted ticks, two flop stages
        chk({7'h00, n >= 13 * nd + 3 && n <= 13 * nd + 4},
            8'h01);
        rd(RES);
        chk(rv, ev);
        repeat (20 * nd) @(posedge i_clk);
        rd(CTL);
        chk(rv, {3'h0, ch});
    endtask
    task automatic t_cont();
        int n;
        wr(PRE, 8'h00);
        wr(CTL, 8'h1f);
        wr(CTL, 8'h23);
        poll(60, n);
        chk({7'h00, o_result_settled}, 8'h00);
        @(posedge i_clk);
        bias <= 8'h01;
        repeat (40) @(posedge i_clk);
        #1 chk({7'h00, o_result_settled}, 8'h01);
        rd(RES);
        chk(rv, 8'h34);
        // Restart just after a completion, far from the next one
        poll(60, n);
        wr(CTL, 8'h05);
        poll(60, n);
        rd(RES);
        chk(rv, 8'h54);
        repeat (60) @(posedge i_clk);
        rd(CTL);
        chk(rv, 8'h05);
    endtask
    // Interrupts run with the processor held in wait
    task automatic t_irq();
        @(posedge i_clk);
        i_wait_mode <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(CTL, 8'h42);
            // Let the write's own update land before testing the request
            @(negedge i_clk);
            chk({7'h00, o_conv_irq}, 8'h00);
            repeat (100) begin
                if (o_conv_irq !== 1'b1) @(negedge i_clk);
            end
            chk({7'h00, o_conv_irq}, 8'h01);
            rd(CTL);
            chk(rv, 8'h42);
        end
        wr(CTL, 8'h02);
        #1 chk({7'h00, o_conv_irq}, 8'h00);
        wr(CTL, 8'h42);
        repeat (40) @(posedge i_clk);
        rd(RES);
        chk(rv, 8'h24);
        chk({7'h00, o_conv_irq}, 8'h00);
        // Converter not needed for waking, so power it down
        wr(CTL, 8'h1f);
        #1 chk({7'h00, o_core_power}, 8'h00);
    endtask
    task automatic stop_mid(input logic [7:0] c);
        wr(CTL, c);
        repeat (5) @(posedge i_clk);
        i_stop_mode <= 1'b1;
        repeat (40) @(posedge i_clk);
        i_stop_mode <= 1'b0;
    endtask
    task automatic t_stop();
        int n;
        stop_mid(8'h24);
        poll(60, n);
        chk(rv, 8'ha4);
        // First result after stop is unsettled, the next one is good
        chk({7'h00, o_result_settled}, 8'h00);
        repeat (14) @(posedge i_clk);
        #1 chk({7'h00, o_result_settled}, 8'h01);
        stop_mid(8'h04);
        repeat (60) @(posedge i_clk);
        rd(CTL);
        chk(rv, 8'h04);
    endtask
    initial begin
        logic [4:0] codes [8];
        logic [2:0] divs [8];
        codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1d, 5'h1e};
        // Code 010 divides by four, the usual setting
        divs = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0, 3'h5};
        i_sys_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_stop_mode = 1'b0;
        i_wait_mode = 1'b0;
        bias = 8'h00;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        for (int i = 0; i < 8; i++) begin
            t_single(codes[i], divs[i]);
        end
        t_cont();
        t_irq();
        t_stop();
        give_verdict();
    end
endmodule // sac_converter_control_tb

// ===== dv/sac_core_model.sv
// Behavioural model of the analog core and its shared port pins
`timescale 1ns/1ps
module sac_core_model (
    input wire logic i_clk,
    input wire logic i_power,
    input wire logic [1:0] i_ref_sel,
    input wire logic [5:0] i_pin_analog,
    input wire logic [7:0] i_bias,
    output logic [7:0] o_result
);
    logic [7:0] pin_code; // Code of the forced pin
    logic [7:0] noise = 8'h5a; // Changes every cycle, never stale
    // Pin k converts to k3 hex plus bias
    always_comb begin
        pin_code = 8'h00;
        for (int k = 0; k < 6; k++) begin
            if (i_pin_analog[k]) pin_code = {k[3:0], 4'h3} + i_bias;
        end
    end
    always_ff @(posedge i_clk) begin
        noise <= noise + 8'h3b;
    end
    // Off or unused input gives garbage, references full or zero scale
    assign o_result = (!i_power || i_ref_sel == 2'h3) ? noise :
        i_ref_sel == 2'h1 ? 8'hff : i_ref_sel == 2'h2 ? 8'h00 :
        pin_code;
endmodule // sac_core_model

// ===== dv/sac_properties.sv
// Port-level assertions of the converter control block
`timescale 1ns/1ps
module sac_properties #(
    parameter int NUM_CH = 6
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_stop_mode,
    input wire logic i_wait_mode,
    input wire logic [7:0] i_core_result,
    input wire logic o_core_power,
    input wire logic [1:0] o_core_ref_sel,
    input wire logic [NUM_CH-1:0] o_pin_analog,
    input wire logic o_conv_irq,
    input wire logic o_result_settled
);
    // Decoded accesses and the written channel code
    wire logic wr_ctl = i_wr && i_addr == sac_pkg::OFF_STATUS_CONTROL;
    wire logic rd_res = i_rd && i_addr == sac_pkg::OFF_RESULT;
    wire logic [4:0] wch = i_wdata[4:0];
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Two cycles of slack allow one register stage on the request
    a_wr_drops_irq: assert property (wr_ctl && !i_wdata[6]
        |-> ##2 !o_conv_irq) else $error("irq kept after control write");
    a_rd_drops_irq: assert property (rd_res && o_conv_irq
        |=> !o_conv_irq) else $error("irq kept after result read");
    a_off_unpowers: assert property (wr_ctl && wch == 5'h1f
        |-> ##2 !o_core_power) else $error("core powered on code off");
    a_stop_unpowers: assert property (i_stop_mode [*3]
        |-> !o_core_power) else $error("core powered in stop");
    a_pin_onehot: assert property ($onehot0(o_pin_analog))
        else $error("more than one pin forced");
    a_pin_follows: assert property (wr_ctl && wch < 5'h06
        && !i_stop_mode ##1 !i_wr && !i_stop_mode
        |-> ##1 o_pin_analog == NUM_CH'(1) << $past(wch, 2))
        else $error("forced pin differs from channel");
    a_ref_follows: assert property (wr_ctl && !i_stop_mode
        && (wch == 5'h1d || wch == 5'h1e) ##1 !i_wr && !i_stop_mode
        |-> ##1 o_core_ref_sel == ($past(i_wdata[1], 2) ? 2'h2 : 2'h1))
        else $error("reference select wrong");
    a_irq_powered: assert property ($rose(o_conv_irq)
        |-> $past(o_core_power, 2)) else $error("irq without power");
endmodule // sac_properties

bind sac_converter_control sac_properties #(.NUM_CH(NUM_CH)) i_sac_properties (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_stop_mode(i_stop_mode), .i_wait_mode(i_wait_mode),
    .i_core_result(i_core_result), .o_core_power(o_core_power),
    .o_core_ref_sel(o_core_ref_sel), .o_pin_analog(o_pin_analog),
    .o_conv_irq(o_conv_irq), .o_result_settled(o_result_settled));

// ===== src/sac_converter_control.sv
// Top of the successive-approximation converter control logic
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module sac_converter_control #(
    parameter int NUM_CH = 6
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Processor power modes
    input wire logic i_stop_mode,
    input wire logic i_wait_mode,
    // Analog core and shared port pins
    input wire logic [7:0] i_core_result,
    output logic o_core_power,
    output logic [1:0] o_core_ref_sel,
    output logic [NUM_CH-1:0] o_pin_analog,
    // Status to the processor
    output logic o_conv_irq,
    output logic o_result_settled
);
    // Six port pins can be shared; a narrower build drops the high ones
    // A count the channel code cannot reach is refused outright
    initial begin
        if (NUM_CH < 1 || NUM_CH > 6) begin
            $error("sac_converter_control: bad channel count");
        end
    end

    // True for the all-ones code that shuts the converter down; used by
    // start, abort, power_w and the o_core_power output, so kept in one place
    // A single definition keeps all of them agreeing on the code
    function automatic logic chan_off(input logic [4:0] code);
        return code == sac_pkg::CH_POWER_OFF;
    endfunction

    // Software-visible state, plus the settle and stop trackers
    // Everything software can read back lives in these flops
    logic irq_en_r; // Interrupt enable
    logic cont_r; // Continuous mode
    logic [4:0] chan_r; // Channel select
    logic [2:0] div_r; // Prescale select
    logic [7:0] result_r; // Result, no reset value needed
    logic done_r; // Completion flag, also pending request
    logic settled_r; // A full period passed since power-up
    logic stop_d_r; // Stop level one cycle ago

    // Bus decode; a write to the result or to an unmapped address
    // matches nothing and is dropped, reads of holes return zero
    // Decodes use the full address so aliases cannot disturb the block
    logic wr_ctl_w;
    logic wr_div_w;
    logic rd_ctl_w;
    logic rd_res_w;
    logic rd_div_w;
    assign wr_ctl_w = i_wr && (i_addr == sac_pkg::OFF_STATUS_CONTROL);
    assign wr_div_w = i_wr && (i_addr == sac_pkg::OFF_CLOCK_PRESCALE);
    assign rd_ctl_w = i_rd && (i_addr == sac_pkg::OFF_STATUS_CONTROL);
    assign rd_res_w = i_rd && (i_addr == sac_pkg::OFF_RESULT);
    assign rd_div_w = i_rd && (i_addr == sac_pkg::OFF_CLOCK_PRESCALE);

    // Converter enabled unless powered off or stopped
    logic power_w;
    logic active_w;
    logic [4:0] chan_new_w;
    logic off_new_w;
    // Channel in force this cycle: a control write counts at once, so
    // start, abort and the core outputs all act on the new settings
    assign chan_new_w = wr_ctl_w ? i_wdata[sac_pkg::CH_MSB:0] : chan_r;
    assign off_new_w = chan_off(chan_new_w);
    assign power_w = !chan_off(chan_r);
    // Wait mode is deliberately not a term here
    assign active_w = power_w && !i_stop_mode;

    // Start on control write; leaving stop resumes a continuous run
    // A single conversion cut by stop is not restarted: software asked
    // for one result and must write again to get it
    logic start_w;
    logic resume_w;
    logic abort_w;
    assign resume_w = stop_d_r && !i_stop_mode && cont_r && power_w;
    assign start_w = (wr_ctl_w && !off_new_w && !i_stop_mode) ||
                     resume_w;
    // Abort judges the new channel, not the old one: a write that wakes
    // the converter from power-off must start a conversion, while the
    // old code would still read as off in that very cycle
    assign abort_w = off_new_w || i_stop_mode;

    // Links between the divider, the sequencer and the registers
    logic tick_w;
    logic busy_w;
    logic done_w;

    // Conversion clock enable, realigned by every start
    // Restarting the divider on a write puts the first conversion edge
    // a fixed time after it, whatever the divider phase was
    sac_prescaler #(
        .CNT_W(4)
    ) u_presc (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_restart(start_w),
        .i_div_sel(div_r),
        .o_tick(tick_w)
    );

    // Twelve-clock conversion sequencer
    // Abort wins over start inside, so a stop or power-off can never
    // leave a conversion half counted
    sac_sequencer #(
        .CONV_LEN(sac_pkg::CONV_CLOCKS)
    ) u_seq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick_w),
        .i_start(start_w),
        .i_abort(abort_w),
        .i_continuous(cont_r),
        .o_busy(busy_w),
        .o_done(done_w)
    );

    // Clear on control write or result read; a completion wins
    // Letting the set win means a result landing beside a clear is
    // still announced, at the price of a flag that may look stale
    logic clr_w;
    logic done_nxt;
    assign clr_w = wr_ctl_w || rd_res_w;
    assign done_nxt = done_w ? 1'b1 : (clr_w ? 1'b0 : done_r);

    // Control register, reset leaves the converter off
    // Bit 7 of the write is ignored: the done flag belongs to hardware
    // Irq enable, continuous and channel all take effect together
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_en_r <= 1'b0;
            cont_r <= 1'b0;
            chan_r <= sac_pkg::RST_CHANNEL;
        end else if (wr_ctl_w) begin
            irq_en_r <= i_wdata[sac_pkg::BIT_IRQ_EN];
            cont_r <= i_wdata[sac_pkg::BIT_CONT];
            chan_r <= i_wdata[sac_pkg::CH_MSB:0];
        end
    end

    // Prescale register
    // Only the top three bits are stored; the low five read as zero
    // A change mid-conversion alters the length of that conversion
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_r <= sac_pkg::RST_PRESCALE;
        end else if (wr_div_w) begin
            div_r <= i_wdata[7:sac_pkg::DIV_LSB];
        end
    end

    // Completion flag and stop edge tracker
    // The flag doubles as the pending request; only the read view and
    // the request output tell the two uses apart
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            done_r <= 1'b0;
            stop_d_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
            stop_d_r <= i_stop_mode;
        end
    end

    // Result loaded at every completion, even if unread
    // No reset: the value is undefined until the first completion,
    // which saves a reset net on flops nobody may rely on anyway
    always_ff @(posedge i_clk) begin
        if (done_w) begin
            result_r <= i_core_result;
        end
    end

    // First conversion after power-up or stop is not settled
    // The analog side needs one full period after waking, so the
    // first completion only arms the settled state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            settled_r <= 1'b0;
        end else if (!active_w) begin
            settled_r <= 1'b0;
        end else if (done_w) begin
            settled_r <= 1'b1;
        end
    end

    // Settled indication follows the result it qualifies
    // Loaded on the same edge as the result so the two never disagree
    logic settled_res_r;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            settled_res_r <= 1'b0;
        end else if (done_w) begin
            settled_res_r <= settled_r;
        end
    end
    assign o_result_settled = settled_res_r;

    // Read data mux; flag masked to zero while irq enabled
    // Idle cycles return zero so stale data never lingers on the bus
    logic [7:0] ctl_view_w;
    logic [7:0] rdata_nxt;
    assign ctl_view_w = {done_r && !irq_en_r, irq_en_r, cont_r,
                         chan_r};
    assign rdata_nxt = rd_ctl_w ? ctl_view_w :
                       rd_res_w ? result_r :
                       rd_div_w ? {div_r, 5'h00} : 8'h00;

    // Read data register, valid the cycle after the strobe
    // One flop stage keeps the address decode off the output path
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_nxt;
        end
    end

    // Interrupt request is the pending flag when enabled
    // It follows the flag, so it drops on the very accesses that clear
    // the flag, and stays low whenever the enable is clear
    // Nothing here depends on wait mode, so it can wake the processor
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_conv_irq <= 1'b0;
        end else begin
            // Enable is sampled live so a write that disables drops it
            o_conv_irq <= done_nxt && (wr_ctl_w ?
                          i_wdata[sac_pkg::BIT_IRQ_EN] : irq_en_r);
        end
    end

    // Analog select to the core
    // Unused and reserved codes get no input at all; their result is
    // undefined anyway, so nothing is gained by picking a pin
    // Power-off also maps to no input, leaving every pin to the port
    logic [1:0] ref_w;
    assign ref_w = (chan_new_w == sac_pkg::CH_REF_HIGH) ? sac_pkg::SEL_HIGH :
                   (chan_new_w == sac_pkg::CH_REF_LOW) ? sac_pkg::SEL_LOW :
                   (chan_new_w <= sac_pkg::CH_LAST_EXT) ? sac_pkg::SEL_EXT :
                   sac_pkg::SEL_NONE;

    // Pin override: only the selected external channel
    // Every other pin stays with the port logic; the override follows
    // the channel written, not whether a conversion is running
    logic [NUM_CH-1:0] pin_w;
    always_comb begin
        pin_w = '0;
        for (int k = 0; k < NUM_CH; k++) begin
            pin_w[k] = (chan_new_w == 5'(k));
        end
    end

    // Core control outputs registered
    // Flops give the core and the pin drivers glitch-free levels
    // Power, select and override all change on the same edge
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_core_power <= 1'b0;
            o_core_ref_sel <= sac_pkg::SEL_NONE;
            o_pin_analog <= '0;
        end else begin
            o_core_power <= !off_new_w &&
                            !i_stop_mode;
            o_core_ref_sel <= ref_w;
            o_pin_analog <= pin_w;
        end
    end

    // Busy and wait level are kept for visibility only through behaviour
    // Busy is not a port; the sequencer shows only through its results
    logic unused_w;
    assign unused_w = busy_w ^ i_wait_mode;
endmodule // sac_converter_control

// ===== src/sac_pkg.sv
// Package of register map, field layout and timing constants for the converter
package sac_pkg;
    // Register offsets on the register port
    localparam logic [7:0] OFF_STATUS_CONTROL = 8'h5d;
    localparam logic [7:0] OFF_RESULT = 8'h5e;
    localparam logic [7:0] OFF_CLOCK_PRESCALE = 8'h5f;
    // Status/control field positions
    localparam int BIT_DONE = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_CONT = 5;
    localparam int CH_MSB = 4;
    // Prescale field position
    localparam int DIV_LSB = 5;
    // Reset values
    localparam logic [4:0] RST_CHANNEL = 5'h1f;
    localparam logic [2:0] RST_PRESCALE = 3'h0;
    // Channel codes
    localparam logic [4:0] CH_LAST_EXT = 5'h05;
    localparam logic [4:0] CH_RESERVED = 5'h1b;
    localparam logic [4:0] CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] CH_REF_LOW = 5'h1e;
    localparam logic [4:0] CH_POWER_OFF = 5'h1f;
    // Conversion length in conversion clocks
    localparam int CONV_CLOCKS = 12;
    // Largest prescale division
    localparam int MAX_DIV = 16;
    // Analog select codes driven to the core
    localparam logic [1:0] SEL_EXT = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_LOW = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;
endpackage

// ===== src/sac_prescaler.sv
// Bus clock divider that makes the conversion clock enable pulse
`timescale 1ns/1ps
module sac_prescaler #(
    parameter int CNT_W = 4
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_restart,
    input wire logic [2:0] i_div_sel,
    output logic o_tick
);
    initial begin
        if ((1 << CNT_W) < sac_pkg::MAX_DIV) begin
            $error("sac_prescaler: counter too narrow");
        end
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] top_w;
    logic tick_w;

    // Terminal count per divide code, top bit forces divide by 16
    assign top_w = i_div_sel[2] ? CNT_W'(15) :
                   CNT_W'((1 << i_div_sel[1:0]) - 1);
    assign tick_w = (cnt_r >= top_w);
    // Restart aligns the first edge to just after a control write
    assign cnt_nxt = (i_restart || tick_w) ? '0 : cnt_r + CNT_W'(1);

    // Divider counter
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // One bus-cycle enable per conversion clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= tick_w && !i_restart;
        end
    end
endmodule // sac_prescaler

// ===== src/sac_sequencer.sv
// Conversion sequencer counting conversion clocks per conversion
`timescale 1ns/1ps
module sac_sequencer #(
    parameter int CONV_LEN = sac_pkg::CONV_CLOCKS
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_continuous,
    output logic o_busy,
    output logic o_done
);
    initial begin
        if (CONV_LEN < 2 || CONV_LEN > 255) begin
            $error("sac_sequencer: bad conversion length");
        end
    end

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_RUN = 2'b10
    } sac_seq_type;

    sac_seq_type st_r;
    sac_seq_type st_nxt;
    logic [7:0] cnt_r;
    logic last_w;

    assign last_w = (cnt_r == 8'(CONV_LEN - 1));
    assign o_busy = (st_r != SEQ_IDLE);

    // Next state, start and abort take priority over counting
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SEQ_IDLE: st_nxt = SEQ_IDLE;
            SEQ_ARMED: if (i_tick) st_nxt = SEQ_RUN;
            SEQ_RUN: begin
                if (i_tick && last_w) begin
                    st_nxt = i_continuous ? SEQ_RUN : SEQ_IDLE;
                end
            end
            default: st_nxt = SEQ_IDLE;
        endcase
        if (i_start) st_nxt = SEQ_ARMED;
        if (i_abort) st_nxt = SEQ_IDLE;
    end

    // State and clock counter
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= SEQ_IDLE;
            cnt_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (i_start || i_abort || st_r != SEQ_RUN) begin
                cnt_r <= 8'h00;
            end else if (i_tick) begin
                cnt_r <= last_w ? 8'h00 : cnt_r + 8'h01;
            end
        end
    end

    // Completion pulse on the twelfth conversion clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (st_r == SEQ_RUN) && i_tick && last_w &&
                      !i_start && !i_abort;
        end
    end
endmodule // sac_sequencer
